// file: spi_word_gap_and_swap_ctrl.sv
// Word gap, byte swap, role select and unit-done interrupt control.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "spi_gap_defines.svh"
module spi_word_gap_and_swap_ctrl (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        BYTE_DONE,
    input  wire logic        WORD_DONE,
    input  wire logic        TX_FIFO_EMPTY,
    input  wire logic        HALF_TICK,
    output logic             IRQ,
    output logic             SLAVE_MODE,
    output logic             SWAP_ACTIVE,
    output logic             VARCLK_ACTIVE,
    output logic      [5:0]  WORD_BITS,
    output logic             GAP_HOLD
);

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    logic                    varclk_reg;
    logic                    varclk_next;
    logic                    swap_req_reg;
    logic                    swap_req_next;
    logic                    slave_reg;
    logic                    slave_next;
    logic [3:0]              gap_reg;
    logic [3:0]              gap_next;
    logic [4:0]              len_reg;
    logic [4:0]              len_next;
    logic                    dual_reg;
    logic                    dual_next;
    logic [`STAT_BITS-1:0]   mask_reg;
    logic [`STAT_BITS-1:0]   mask_next;

    // ------------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------------
    logic                    wr_ctrl;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    wr_aux;

    assign wr_ctrl   = WR && (ADDR == `CTRL_OFFSET);
    assign wr_status = WR && (ADDR == `STATUS_OFFSET);
    assign wr_mask   = WR && (ADDR == `MASK_OFFSET);
    assign wr_aux    = WR && (ADDR == `AUX_OFFSET);

    // ------------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------------
    // A field keeps its value unless its own register is written.
    // Bits outside the listed fields are dropped, so a wide write cannot reach them.
    always_comb begin
        varclk_next   = varclk_reg;
        swap_req_next = swap_req_reg;
        slave_next    = slave_reg;
        gap_next      = gap_reg;
        len_next      = len_reg;
        dual_next     = dual_reg;
        mask_next     = mask_reg;
        if (wr_ctrl) begin
            varclk_next   = WDATA[`CTRL_VARCLK_BIT];
            swap_req_next = WDATA[`CTRL_SWAP_BIT];
            slave_next    = WDATA[`CTRL_SLAVE_BIT];
            gap_next      = WDATA[`CTRL_GAP_MSB:`CTRL_GAP_LSB];
            len_next      = WDATA[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
            // The enable bit here and mask bit zero are the same flop.
            mask_next[`STAT_DONE_BIT] = WDATA[`CTRL_IE_BIT];
        end
        if (wr_mask) begin
            mask_next = WDATA[`STAT_BITS-1:0];
        end
        if (wr_aux) begin
            dual_next = WDATA[`AUX_DUAL_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            varclk_reg   <= 1'b0;
            swap_req_reg <= 1'b0;
            slave_reg    <= 1'b0;
            gap_reg      <= `GAP_RESET; // RULE11
            len_reg      <= `LEN_RESET;
            dual_reg     <= 1'b0;
            mask_reg     <= '0;
        end else begin
            varclk_reg   <= varclk_next;
            swap_req_reg <= swap_req_next;
            slave_reg    <= slave_next;
            gap_reg      <= gap_next;
            len_reg      <= len_next;
            dual_reg     <= dual_next;
            mask_reg     <= mask_next;
        end
    end

    // ------------------------------------------------------------------------
    // Derived modes
    // ------------------------------------------------------------------------
    logic       len_swappable;
    logic       swap_ok;
    logic       swap_refused;
    logic       refused_seen_reg;
    logic       refused_seen_next;
    logic [5:0] word_bits_calc;
    logic       is_master;

    // A role change acts at once, so software should switch role only while idle.
    assign is_master = !slave_reg; // RULE5

    // Code zero stands for a full 32-bit word.
    assign word_bits_calc = (len_reg == `LEN_32_CODE) ? `WORD_32_BITS : {1'b0, len_reg}; // RULE13

    // Only words of two, three or four whole bytes can be reordered.
    assign len_swappable = (len_reg == `LEN_16_CODE) || (len_reg == `LEN_24_CODE)
                        || (len_reg == `LEN_32_CODE); // RULE2

    // Swapping is simply withheld in unsupported setups and reported as refused.
    // Software must keep swap off while the variable clock or dual I/O is in use.
    assign swap_ok      = swap_req_reg && len_swappable && !varclk_reg && !dual_reg; // RULE4
    assign swap_refused = swap_req_reg && !swap_ok;

    // ------------------------------------------------------------------------
    // Swap refusal event
    // ------------------------------------------------------------------------
    // Only the start of a refusal raises the event, not every cycle of it.
    always_comb begin
        refused_seen_next = swap_refused;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            refused_seen_reg <= 1'b0;
        end else begin
            refused_seen_reg <= refused_seen_next;
        end
    end

    // ------------------------------------------------------------------------
    // Gap timing
    // ------------------------------------------------------------------------
    logic start_word;
    logic start_byte;
    logic gap_extra;
    logic gap_hold_int;

    // In slave role the far master times every gap and keeps select active through
    // the byte gaps, so the local timer stays idle.
    assign start_word = is_master && WORD_DONE && !TX_FIFO_EMPTY; // RULE9 RULE3
    assign start_byte = is_master && swap_ok && BYTE_DONE && !WORD_DONE; // RULE1
    // The variable clock adds twelve half periods so the next word never starts early.
    assign gap_extra  = varclk_reg && !TX_FIFO_EMPTY; // RULE12

    gap_timer u_gap_timer (
        .clk        (CORE_CLK),
        .rst        (RST),
        .start_word (start_word),
        .start_byte (start_byte),
        .gap        (gap_reg),
        .extra      (gap_extra),
        .half_tick  (HALF_TICK),
        .hold       (gap_hold_int)
    );

    // ------------------------------------------------------------------------
    // Status flags and interrupt
    // ------------------------------------------------------------------------
    logic [`STAT_BITS-1:0] stat_set;
    logic [`STAT_BITS-1:0] stat_clr;
    logic [`STAT_BITS-1:0] stat;

    // A done pulse beside a clear leaves the flag set.
    // Software then sees the newer transfer instead of losing it.
    always_comb begin
        stat_set = '0;
        stat_clr = '0;
        stat_set[`STAT_DONE_BIT]   = WORD_DONE; // RULE7
        stat_set[`STAT_REFUSE_BIT] = swap_refused && !refused_seen_reg;
        if (wr_status) begin
            stat_clr = WDATA[`STAT_BITS-1:0]; // RULE8
        end
        if (wr_ctrl && WDATA[`CTRL_IF_BIT]) begin
            stat_clr[`STAT_DONE_BIT] = 1'b1; // RULE8
        end
    end

    // ------------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `STAT_BITS; gi = gi + 1) begin : g_stat
            irq_flag u_flag (
                .clk (CORE_CLK),
                .rst (RST),
                .set (stat_set[gi]),
                .clr (stat_clr[gi]),
                .q   (stat[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    logic       irq_reg;
    logic       irq_next;
    logic       slave_out_reg;
    logic       swap_out_reg;
    logic       varclk_out_reg;
    logic [5:0] bits_out_reg;

    // The interrupt is a level that follows the flags one cycle late.
    // Clearing a flag or its enable drops the line at the next edge.
    always_comb begin
        irq_next = |(stat & mask_reg); // RULE6 RULE15
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            irq_reg        <= 1'b0;
            slave_out_reg  <= 1'b0;
            swap_out_reg   <= 1'b0;
            varclk_out_reg <= 1'b0;
            bits_out_reg   <= `WORD_32_BITS;
        end else begin
            irq_reg        <= irq_next;
            slave_out_reg  <= slave_reg; // RULE5
            swap_out_reg   <= swap_ok; // RULE2
            varclk_out_reg <= varclk_reg && is_master; // RULE14
            bits_out_reg   <= word_bits_calc; // RULE13
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        // Unmapped addresses and idle cycles read as zero.
        rdata_next = 32'h0000_0000;
        if (RD) begin
            case (ADDR)
                `CTRL_OFFSET: begin
                    rdata_next[`CTRL_VARCLK_BIT]             = varclk_reg;
                    rdata_next[`CTRL_SWAP_BIT]               = swap_req_reg;
                    rdata_next[`CTRL_SLAVE_BIT]              = slave_reg;
                    rdata_next[`CTRL_IE_BIT]                 = mask_reg[`STAT_DONE_BIT];
                    rdata_next[`CTRL_IF_BIT]                 = stat[`STAT_DONE_BIT];
                    rdata_next[`CTRL_GAP_MSB:`CTRL_GAP_LSB]  = gap_reg;
                    rdata_next[`CTRL_LEN_MSB:`CTRL_LEN_LSB]  = len_reg;
                end
                `STATUS_OFFSET: begin
                    rdata_next[`STAT_BITS-1:0] = stat;
                end
                `MASK_OFFSET: begin
                    rdata_next[`STAT_BITS-1:0] = mask_reg;
                end
                `AUX_OFFSET: begin
                    rdata_next[`AUX_DUAL_BIT] = dual_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data stand for one cycle and then return to zero.
    // Software must take them in the cycle right after the read strobe.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------------------
    assign RDATA         = rdata_reg;
    assign IRQ           = irq_reg;
    assign SLAVE_MODE    = slave_out_reg;
    assign SWAP_ACTIVE   = swap_out_reg;
    assign VARCLK_ACTIVE = varclk_out_reg;
    assign WORD_BITS     = bits_out_reg;
    assign GAP_HOLD      = gap_hold_int;

endmodule

// file: spi_gap_defines.svh
// Constants for the word gap, byte swap and role control block.
//
// Summary of operation
// (RULE1) With byte swapping on, an idle gap of the inter-word length follows each byte.
// (RULE2) Byte swapping works only for 16, 24 or 32 bit words.
// (RULE3) A slave's master keeps level select active through each per-byte gap.
// (RULE4) Byte swapping is refused while the variable clock or dual I/O is on.
// (RULE5) Role bit clear selects master, set selects slave.
// (RULE6) Interrupt enable passes the unit-done request when 1, blocks it when 0.
// (RULE7) The done flag sets at each completed unit transfer, else reads 0.
// (RULE8) The done flag clears only by writing 1; writing 0 keeps it.
// (RULE9) In master role a 4-bit field sets the idle time between words.
// (RULE10) The inter-word gap lasts field value plus one half bus clock periods.
// (RULE11) After reset the gap field holds 0x3, giving 3.5 periods.
// (RULE12) With variable clock and queued data, the gap is 6.5 plus field periods.
// (RULE13) Word length field gives 8 to 31 bits directly; 0x00 means 32 bits.
// (RULE14) With variable clock enabled the master's bus clock comes from the variable pattern.
// (RULE15) The interrupt stands while done flag and its enable are both set.
`ifndef SPI_GAP_DEFINES_SVH
`define SPI_GAP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CTRL_OFFSET      8'h00
`define STATUS_OFFSET    8'h08
`define MASK_OFFSET      8'h0c
`define AUX_OFFSET       8'h10

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_VARCLK_BIT  23
`define CTRL_SWAP_BIT    19
`define CTRL_SLAVE_BIT   18
`define CTRL_IE_BIT      17
`define CTRL_IF_BIT      16
`define CTRL_GAP_MSB     15
`define CTRL_GAP_LSB     12
`define CTRL_LEN_MSB     7
`define CTRL_LEN_LSB     3
`define AUX_DUAL_BIT     0

// ----------------------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------------------
`define STAT_BITS        2
`define STAT_DONE_BIT    0
`define STAT_REFUSE_BIT  1

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define GAP_RESET        4'h3
`define LEN_RESET        5'h00
`define LEN_32_CODE      5'h00
`define LEN_16_CODE      5'h10
`define LEN_24_CODE      5'h18
`define WORD_32_BITS     6'h20
`define VARCLK_EXTRA     6'h0c

`endif

// file: spi_gap_pkg.sv
// Types shared by the word gap, byte swap and role control block.
package spi_gap_pkg;

    typedef enum logic [1:0] {
        GAP_IDLE,
        GAP_WORD,
        GAP_BYTE
    } gap_state_t;

endpackage

// file: irq_flag.sv
// One sticky status bit, set by hardware and cleared by writing one.
`timescale 1ns/1ps
module irq_flag (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);

    logic q_reg;
    logic q_next;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        q_next = q_reg;
        if (set) begin
            q_next = 1'b1;
        end else if (clr) begin
            q_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule

// file: gap_timer.sv
// Times the idle gap after a word or a byte in half bus clock periods.
`timescale 1ns/1ps
`include "spi_gap_defines.svh"
module gap_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start_word,
    input  wire logic       start_byte,
    input  wire logic [3:0] gap,
    input  wire logic       extra,
    input  wire logic       half_tick,
    output logic            hold
);

    spi_gap_pkg::gap_state_t state_reg;
    spi_gap_pkg::gap_state_t state_next;
    logic [5:0]              count_reg;
    logic [5:0]              count_next;
    logic                    hold_reg;
    logic                    hold_next;
    logic [5:0]              base_halves;

    // Gap value plus one half is 2*gap+1 half periods.
    assign base_halves = {1'b0, gap, 1'b1}; // RULE10

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            spi_gap_pkg::GAP_IDLE: begin
                if (start_word) begin
                    state_next = spi_gap_pkg::GAP_WORD;
                    count_next = extra ? base_halves + `VARCLK_EXTRA : base_halves; // RULE12
                end else if (start_byte) begin
                    state_next = spi_gap_pkg::GAP_BYTE;
                    count_next = base_halves; // RULE1
                end
            end
            spi_gap_pkg::GAP_WORD, spi_gap_pkg::GAP_BYTE: begin
                if (half_tick) begin
                    if (count_reg == 6'h01) begin
                        state_next = spi_gap_pkg::GAP_IDLE;
                        count_next = 6'h00;
                    end else begin
                        count_next = count_reg - 6'h01;
                    end
                end
            end
            default: begin
                state_next = spi_gap_pkg::GAP_IDLE;
                count_next = 6'h00;
            end
        endcase
        hold_next = (state_next != spi_gap_pkg::GAP_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= spi_gap_pkg::GAP_IDLE;
            count_reg <= 6'h00;
            hold_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            hold_reg  <= hold_next;
        end
    end

    assign hold = hold_reg;

endmodule

// file: spi_gap_checker.sv
// Concurrent checks on the ports of the word gap, byte swap and interrupt block.
`timescale 1ns/1ps
module spi_gap_checker (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        BYTE_DONE,
    input wire logic        WORD_DONE,
    input wire logic        TX_FIFO_EMPTY,
    input wire logic        HALF_TICK,
    input wire logic        IRQ,
    input wire logic        SLAVE_MODE,
    input wire logic        SWAP_ACTIVE,
    input wire logic        VARCLK_ACTIVE,
    input wire logic [5:0]  WORD_BITS,
    input wire logic        GAP_HOLD
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    // --------------------------------
    // Sequences
    // --------------------------------
    // Without a write last cycle the registered role equals the role bit.
    sequence s_master;
        !SLAVE_MODE && !$past(WR);
    endsequence
    sequence s_slave;
        SLAVE_MODE && !$past(WR);
    endsequence
    sequence s_word_end;
        WORD_DONE && !TX_FIFO_EMPTY && !GAP_HOLD;
    endsequence

    a_gap_start: assert property (s_master ##0 s_word_end |=> GAP_HOLD)
        else $error("Word gap did not start");
    a_slave_quiet: assert property (s_slave ##0 !GAP_HOLD |=> !GAP_HOLD)
        else $error("Gap started in slave role");
    a_gap_cause: assert property (!GAP_HOLD && !WORD_DONE && !BYTE_DONE |=> !GAP_HOLD)
        else $error("Gap started without cause");
    a_gap_holds: assert property (GAP_HOLD && !HALF_TICK |=> GAP_HOLD)
        else $error("Gap ended without a half tick");
    a_swap_legal: assert property (SWAP_ACTIVE |-> !VARCLK_ACTIVE &&
        (WORD_BITS == 6'h10 || WORD_BITS == 6'h18 || WORD_BITS == 6'h20))
        else $error("Swap active in an unsupported mode");
    a_varclk_role: assert property (SLAVE_MODE |-> !VARCLK_ACTIVE)
        else $error("Variable clock active in slave role");
    a_len_range: assert property (WORD_BITS >= 6'h08 && WORD_BITS <= 6'h20)
        else $error("Word length out of range");
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("Read data outside read cycle");
    a_irq_fall: assert property ($fell(IRQ) |-> $past(WR, 2))
        else $error("Interrupt fell without a write");
endmodule

bind spi_word_gap_and_swap_ctrl spi_gap_checker i_spi_gap_checker (
    .CORE_CLK(CORE_CLK), .RST(RST), .WR(WR), .RD(RD), .RDATA(RDATA),
    .BYTE_DONE(BYTE_DONE), .WORD_DONE(WORD_DONE), .TX_FIFO_EMPTY(TX_FIFO_EMPTY),
    .HALF_TICK(HALF_TICK), .IRQ(IRQ), .SLAVE_MODE(SLAVE_MODE), .SWAP_ACTIVE(SWAP_ACTIVE),
    .VARCLK_ACTIVE(VARCLK_ACTIVE), .WORD_BITS(WORD_BITS), .GAP_HOLD(GAP_HOLD));

// file: shift_model.sv
// Behavioural shifter and divider answering the block with byte and word events.
`timescale 1ns/1ps
module shift_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [1:0] bytes_m1,
    input  wire logic       hold,
    output logic            half_tick,
    output logic            byte_done,
    output logic            word_done
);
    logic       phase;
    logic       busy;
    logic [1:0] left;
    int         cnt;

    // The bus clock runs only for bits and gaps, and the frame stays open through byte gaps only.
    always_ff @(posedge clk) begin
        half_tick <= 1'b0;
        byte_done <= 1'b0;
        word_done <= 1'b0;
        phase     <= ~phase;
        if (rst) begin
            busy  <= 1'b0;
            phase <= 1'b0;
            cnt   <= 0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            left <= bytes_m1;
            cnt  <= 0;
        end else if (phase && (busy || hold)) begin
            half_tick <= 1'b1;
            if (busy && !hold) begin
                cnt <= (cnt == 15) ? 0 : cnt + 1;
                if (cnt == 15) begin
                    byte_done <= 1'b1;
                    word_done <= (left == 2'h0);
                    busy      <= (left != 2'h0);
                    left      <= left - 2'h1;
                end
            end
        end
    end
endmodule

// file: spi_word_gap_and_swap_ctrl_test.sv
// Self-checking bench for the word gap, byte swap and interrupt control block.
`timescale 1ns/1ps
`include "spi_gap_defines.svh"
module spi_word_gap_and_swap_ctrl_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        go = 1'b0;
    logic        empty = 1'b1;
    logic [1:0]  nb = 2'h0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [5:0]  bits;
    logic        bdone, wdone, tick, irq, slave, swap, vclk, hold;
    int          error_cnt = 0;
    int          checks_done = 0;

    initial begin
        forever #20 clk = ~clk;
    end

    spi_word_gap_and_swap_ctrl i_spi_word_gap_and_swap_ctrl (
        .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .BYTE_DONE(bdone), .WORD_DONE(wdone), .TX_FIFO_EMPTY(empty),
        .HALF_TICK(tick), .IRQ(irq), .SLAVE_MODE(slave), .SWAP_ACTIVE(swap),
        .VARCLK_ACTIVE(vclk), .WORD_BITS(bits), .GAP_HOLD(hold));
    shift_model i_shift_model (
        .clk(clk), .rst(rst), .start(go), .bytes_m1(nb), .hold(hold),
        .half_tick(tick), .byte_done(bdone), .word_done(wdone));

    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Runs one word and counts the half ticks taken while a gap holds the shifter.
    task automatic gap_run(input logic [31:0] c, input logic e, input logic [1:0] n, int exp);
        int cnt;
        int quiet;
        int seen;
        int t;
        cnt = 0;
        quiet = 0;
        seen = 0;
        wr_reg(`CTRL_OFFSET, c);
        @(posedge clk);
        empty <= e;
        nb <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (t = 0; quiet < 4; t++) begin
            #1;
            cnt = cnt + (hold && tick);
            seen = seen | wdone;
            quiet = hold ? 0 : quiet + seen;
            if (t > 3000) begin
                error_cnt++;
                $display("MISMATCH at %0t: gap run hung", $time);
                conclude;
            end
            @(posedge clk);
        end
        chk(cnt, exp);
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset_map;
        chk({26'h0, bits}, 32'h20);
        wr_reg(8'h04, 32'hffff_ffff);
        rd_reg(8'h04, 32'h0);
        rd_reg(`CTRL_OFFSET, 32'h0000_3000);
    endtask

    task automatic t_length;
        logic [4:0] codes [7] = '{5'h08, 5'h09, 5'h10, 5'h17, 5'h18, 5'h1f, 5'h00};
        logic [5:0] n;
        foreach (codes[i]) begin
            n = (codes[i] == 5'h00) ? 6'h20 : {1'b0, codes[i]};
            wr_reg(`CTRL_OFFSET, {12'h0, 4'h8, 8'h0, codes[i], 3'h0});
            settle;
            chk({26'h0, bits}, {26'h0, n});
            chk({31'h0, swap}, {31'h0, n == 6'h10 || n == 6'h18 || n == 6'h20});
        end
    endtask

    task automatic t_refuse;
        rd_reg(`STATUS_OFFSET, 32'h2);
        wr_reg(`CTRL_OFFSET, 32'h0088_0080);
        settle;
        chk({30'h0, swap, vclk}, 32'h1);
        wr_reg(`AUX_OFFSET, 32'h1);
        wr_reg(`CTRL_OFFSET, 32'h0008_0080);
        settle;
        chk({31'h0, swap}, 32'h0);
        wr_reg(`AUX_OFFSET, 32'h0);
        wr_reg(`CTRL_OFFSET, 32'h0084_0080);
        settle;
        chk({30'h0, slave, vclk}, 32'h2);
    endtask

    task automatic t_gaps;
        gap_run(32'h0000_0080, 1'b0, 2'h0, 1);
        gap_run(32'h0000_f080, 1'b0, 2'h0, 31);
        gap_run(32'h0080_2080, 1'b0, 2'h0, 17);
        gap_run(32'h0000_2080, 1'b1, 2'h0, 0);
        gap_run(32'h0004_2080, 1'b0, 2'h0, 0);
        gap_run(32'h0008_1000, 1'b1, 2'h3, 9);
        gap_run(32'h0008_1080, 1'b0, 2'h1, 6);
        gap_run(32'h0008_1048, 1'b1, 2'h1, 0);
    endtask

    task automatic t_irq;
        wr_reg(`STATUS_OFFSET, 32'h3);
        wr_reg(`MASK_OFFSET, 32'h0);
        gap_run(32'h0000_0080, 1'b1, 2'h0, 0);
        settle;
        chk({31'h0, irq}, 32'h0);
        rd_reg(`STATUS_OFFSET, 32'h1);
        wr_reg(`STATUS_OFFSET, 32'h0);
        wr_reg(`MASK_OFFSET, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h1);
        wr_reg(`CTRL_OFFSET, 32'h0000_0080);
        settle;
        chk({31'h0, irq}, 32'h0);
        rd_reg(`CTRL_OFFSET, 32'h0001_0080);
        wr_reg(`CTRL_OFFSET, 32'h0003_0080);
        settle;
        chk({31'h0, irq}, 32'h0);
        rd_reg(`STATUS_OFFSET, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset_map;
        t_length;
        t_refuse;
        t_gaps;
        t_irq;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`CTRL_OFFSET, 32'h0000_3000);
        conclude;
    end
endmodule
